/* shared/prs_pkg.sv */
// Notes on behaviour
// - Mode three bits 12:11 pick format, bits 1:0 pick the page.
// - Mode three bit 2 redirects reads and writes to the pattern store.
// - Serial and staggered: bit 7 goes out in unit interval 0, bit 0 in interval 7.
// - Page 0 resets to defaults, only page 0 writable, kept until re-init.
// - Page 1 is a read-only log of the errored frame and error status.
// - Page 2 is a read-only copy of mode settings, latencies in location 2.
// - Temperature status field: 00 sub-1x, 01 1x, 10 2x, 11 reserved.
// - Page 3 read-only; only location 3 bits 3:0 carry the activate count.
// - Reads use fixed burst 8 or fixed chop 4, never on the fly.
// - Pattern reads ignore the read inversion enable and never invert.
// - Column 1:0 zero; chop 4 uses A2 to pick half, then four tristate intervals.
// - Bank address 1:0 picks the location; address 7:0 carries the write data.
// - Data bursts after read latency, additive plus CAS latency.
// - Strobes accompany read data with a preamble as in normal reads.
// - Serial repeats the byte on every lane; parallel spreads it over lanes.
// - Staggered: lane i carries location (n+i) mod 4, repeated per nibble.
package prs_pkg;
   // ----------------------------------------
   // command codes
   // ----------------------------------------
   localparam logic [2:0] OP_DES = 3'h0;
   localparam logic [2:0] OP_MRS = 3'h1;
   localparam logic [2:0] OP_RD = 3'h2;
   localparam logic [2:0] OP_WR = 3'h3;
   localparam logic [2:0] OP_REF = 3'h4;
   localparam logic [2:0] OP_RST = 3'h5;
   localparam logic [2:0] OP_RDA = 3'h6;
   localparam logic [2:0] OP_WRA = 3'h7;
   // ----------------------------------------
   // mode register fields
   // ----------------------------------------
   localparam int MR_BITS = 18;
   localparam int EN_BIT = 2;
   localparam int FMT_LO = 11;
   localparam int BL_LO = 0;
   localparam logic [1:0] FMT_SERIAL = 2'h0;
   localparam logic [1:0] FMT_PARALLEL = 2'h1;
   localparam logic [1:0] FMT_STAGGER = 2'h2;
   localparam logic [1:0] BL_CHOP = 2'h2;
   localparam logic [7:0] CL_BASE = 8'h09;
   // ----------------------------------------
   // reset values and fixed bits
   // ----------------------------------------
   localparam logic [31:0] PAT_RESET = 32'h000F3355;
   localparam logic PPR_SUPPORT = 1'b0;
   localparam logic SPPR_SUPPORT = 1'b0;
   localparam int FIFO_DEPTH = 8;
   localparam int FIFO_WIDTH = 46;
   typedef enum logic [1:0] {ST_IDLE = 2'b00, ST_PRE = 2'b01, ST_BURST = 2'b11} prs_state_e;
endpackage : prs_pkg

/* src/prs_pattern_access.sv */
`timescale 1ns/1ns
module prs_fifo
#(
   parameter int WIDTH = 46,
   parameter int DEPTH = 8
)
(
   // clock and reset
   input wire logic clk,
   input wire logic rst_n,
   // fill side
   input wire logic in_valid,
   output logic in_ready,
   input wire logic [WIDTH-1:0] in_data,
   // drain side
   output logic out_valid,
   input wire logic out_ready,
   output logic [WIDTH-1:0] out_data
);
   localparam int AW = $clog2(DEPTH);
   logic [WIDTH-1:0] mem [DEPTH];
   logic [AW-1:0] wr_q;
   logic [AW-1:0] rd_q;
   logic [AW:0] cnt_q;
   logic [AW:0] cnt_d;
   logic push;
   logic pop;
   assign push = in_valid && in_ready;
   assign pop = out_valid && out_ready;
   assign out_valid = (cnt_q != '0);
   assign out_data = mem[rd_q];
   assign cnt_d = cnt_q + (AW+1)'(push) - (AW+1)'(pop);
   always_ff @(posedge clk)
   begin
      if (push)
      begin
         mem[wr_q] <= in_data;
      end
   end
   // ready is registered so the source sees a clean flop
   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         wr_q <= '0;
         rd_q <= '0;
         cnt_q <= '0;
         in_ready <= 1'b1;
      end
      else
      begin
         wr_q <= push ? AW'(wr_q + 1'b1) : wr_q;
         rd_q <= pop ? AW'(rd_q + 1'b1) : rd_q;
         cnt_q <= cnt_d;
         in_ready <= (cnt_d < (AW+1)'(DEPTH));
      end
   end
endmodule : prs_fifo

module prs_pattern_access
(
   // clock and reset
   input wire logic SYS_CLK,
   input wire logic RESET_N,
   // decoded command bus
   input wire logic CMD_VALID,
   input wire logic [2:0] CMD_OP,
   input wire logic [2:0] CMD_MRSEL,
   input wire logic [1:0] CMD_BA,
   input wire logic [prs_pkg::MR_BITS-1:0] CMD_ADDR,
   output logic CMD_READY,
   // error frame capture
   input wire logic ERR_STROBE,
   input wire logic [17:0] ERR_ADDR,
   input wire logic [5:0] ERR_CTRL,
   input wire logic [2:0] ERR_CID,
   input wire logic ERR_CRC,
   input wire logic ERR_PAR,
   // device status
   input wire logic [1:0] TEMP_STATUS,
   input wire logic [3:0] ACT_COUNT,
   // data lanes and strobe
   output logic [7:0] DQ_OUT,
   output logic DQ_OE,
   output logic DQS_OUT,
   output logic DQS_OE,
   output logic PATTERN_ACTIVE
);
   import prs_pkg::*;
   // ----------------------------------------
   // helpers
   // ----------------------------------------
   function automatic logic ui_bit(input logic [7:0] b, input logic [2:0] ui);
      ui_bit = b[3'h7 - ui];
   endfunction : ui_bit

   function automatic logic [7:0] lane_byte(input logic [1:0] fmt, input logic [31:0] pg,
      input logic [1:0] loc, input logic [2:0] ui);
      logic [7:0] r;
      logic [1:0] n;
      r = '0;
      for (int i = 0; i < 8; i++)
      begin
         n = loc + 2'(i);
         unique case (fmt)
            FMT_SERIAL: r[i] = ui_bit(pg[8*loc +: 8], ui);
            FMT_PARALLEL: r[i] = ui_bit(pg[8*loc +: 8], 3'(i % 8));
            FMT_STAGGER: r[i] = ui_bit(pg[8*n +: 8], ui);
            default: r[i] = 1'b0;
         endcase
      end
      lane_byte = r;
   endfunction : lane_byte

   logic [MR_BITS-1:0] mr_q [8];
   logic [31:0] pat_q;
   logic [17:0] el_addr_q;
   logic [5:0] el_ctrl_q;
   logic [2:0] el_cid_q;
   logic el_crc_q;
   logic el_par_q;
   logic [7:0] now_q;
   logic store_en;
   logic [1:0] fmt;
   logic [1:0] page;
   logic [31:0] pg;
   logic is_rd;
   logic is_wr;
   logic [7:0] cl;
   logic [7:0] rl;
   logic chop;
   logic rd_push;
   logic fifo_rdy;
   logic [FIFO_WIDTH-1:0] f_out;
   logic f_valid;
   logic f_pop;
   logic [7:0] wait_diff;
   prs_state_e state_q;
   logic [2:0] ui_q;
   logic [2:0] ui_n;
   logic [FIFO_WIDTH-1:0] cur_q;
   logic cur_chop;
   logic [2:0] cur_idx;

   // ----------------------------------------
   // command decode
   // ----------------------------------------
   assign store_en = mr_q[3][EN_BIT];
   assign fmt = mr_q[3][FMT_LO +: 2];
   assign page = mr_q[3][1:0];
   assign is_rd = CMD_VALID && (CMD_OP == OP_RD || CMD_OP == OP_RDA);
   assign is_wr = CMD_VALID && (CMD_OP == OP_WR || CMD_OP == OP_WRA);
   // setting 01 counts as burst 8, the controller holds A12 high
   assign chop = (mr_q[0][BL_LO +: 2] == BL_CHOP);
   assign cl = CL_BASE + 8'({mr_q[0][12], mr_q[0][6:4], mr_q[0][2]});
   always_comb
   begin
      unique case (mr_q[1][4:3])
         2'h1: rl = cl + cl - 8'h01;
         2'h2: rl = cl + cl - 8'h02;
         default: rl = cl;
      endcase
   end
   assign rd_push = is_rd && store_en && fifo_rdy;
   assign CMD_READY = fifo_rdy;

   // ----------------------------------------
   // page contents
   // ----------------------------------------
   always_comb
   begin
      unique case (page)
         2'h0: pg = pat_q;
         2'h1: pg = {el_crc_q, el_par_q, mr_q[5][2:0], el_cid_q, el_ctrl_q, el_addr_q[17:16],
            el_addr_q[15:8], el_addr_q[7:0]};
         2'h2: pg = {mr_q[1][10:8], mr_q[5][8:6], mr_q[2][2:1],
            mr_q[0][12], mr_q[0][6:4], mr_q[0][2], mr_q[2][5:3],
            mr_q[6][6], mr_q[6][5:0], mr_q[3][3],
            PPR_SUPPORT, SPPR_SUPPORT, mr_q[2][11], TEMP_STATUS,
            mr_q[2][12], mr_q[2][10:9]};
         default: pg = {4'h0, ACT_COUNT, 24'h000000};
      endcase
   end

   // ----------------------------------------
   // mode registers and store
   // ----------------------------------------
   // refresh and deselect leave every register untouched
   always_ff @(posedge SYS_CLK or negedge RESET_N)
   begin
      if (!RESET_N)
      begin
         for (int i = 0; i < 8; i++)
         begin
            mr_q[i] <= '0;
         end
      end
      else if (CMD_VALID && CMD_OP == OP_RST)
      begin
         for (int i = 0; i < 8; i++)
         begin
            mr_q[i] <= '0;
         end
      end
      else if (CMD_VALID && CMD_OP == OP_MRS)
      begin
         mr_q[CMD_MRSEL] <= CMD_ADDR;
      end
   end

   always_ff @(posedge SYS_CLK or negedge RESET_N)
   begin
      if (!RESET_N)
      begin
         pat_q <= PAT_RESET;
      end
      else if (CMD_VALID && CMD_OP == OP_RST)
      begin
         pat_q <= PAT_RESET;
      end
      else if (is_wr && store_en && page == 2'h0)
      begin
         pat_q[8*CMD_BA +: 8] <= CMD_ADDR[7:0];
      end
   end

   // status bits stay set until the device is reset
   always_ff @(posedge SYS_CLK or negedge RESET_N)
   begin
      if (!RESET_N)
      begin
         el_addr_q <= '0;
         el_ctrl_q <= '0;
         el_cid_q <= '0;
         el_crc_q <= 1'b0;
         el_par_q <= 1'b0;
      end
      else if (ERR_STROBE)
      begin
         el_addr_q <= ERR_ADDR;
         el_ctrl_q <= ERR_CTRL;
         el_cid_q <= ERR_CID;
         el_crc_q <= el_crc_q | ERR_CRC;
         el_par_q <= el_par_q | ERR_PAR;
      end
   end

   // ----------------------------------------
   // read queue
   // ----------------------------------------
   always_ff @(posedge SYS_CLK or negedge RESET_N)
   begin
      if (!RESET_N)
      begin
         now_q <= '0;
      end
      else
      begin
         now_q <= now_q + 8'h01;
      end
   end

   // column bits 1:0 are not looked at; the snapshot is taken at the command
   prs_fifo #(.WIDTH(FIFO_WIDTH), .DEPTH(FIFO_DEPTH)) u_fifo
   (
      .clk(SYS_CLK),
      .rst_n(RESET_N),
      .in_valid(rd_push),
      .in_ready(fifo_rdy),
      .in_data({8'(now_q + rl), fmt, chop, CMD_ADDR[2] & chop, CMD_BA, pg}),
      .out_valid(f_valid),
      .out_ready(f_pop),
      .out_data(f_out)
   );

   // ----------------------------------------
   // burst engine
   // ----------------------------------------
   // a queue stalled over 127 cycles would alias the due time
   assign wait_diff = now_q - f_out[45:38];
   assign f_pop = f_valid && state_q == ST_IDLE && !wait_diff[7];
   assign cur_chop = cur_q[35];
   assign ui_n = (state_q == ST_PRE) ? 3'h0 : 3'(ui_q + 3'h1);
   assign cur_idx = ui_n | {cur_q[34], 2'h0};

   always_ff @(posedge SYS_CLK or negedge RESET_N)
   begin
      if (!RESET_N)
      begin
         state_q <= ST_IDLE;
         ui_q <= '0;
         cur_q <= '0;
      end
      else
      begin
         unique case (state_q)
            ST_IDLE:
            begin
               if (f_pop)
               begin
                  cur_q <= f_out;
                  state_q <= ST_PRE;
               end
            end
            ST_PRE:
            begin
               ui_q <= 3'h0;
               state_q <= ST_BURST;
            end
            ST_BURST:
            begin
               ui_q <= ui_n;
               if (ui_q == 3'h7)
               begin
                  state_q <= ST_IDLE;
               end
            end
            default: state_q <= ST_IDLE;
         endcase
      end
   end

   // data never passes through an inversion stage
   always_ff @(posedge SYS_CLK or negedge RESET_N)
   begin
      if (!RESET_N)
      begin
         DQ_OUT <= '0;
         DQ_OE <= 1'b0;
         DQS_OUT <= 1'b0;
         DQS_OE <= 1'b0;
      end
      else if (state_q == ST_PRE || (state_q == ST_BURST && ui_q != 3'h7))
      begin
         DQ_OUT <= lane_byte(cur_q[37:36], cur_q[31:0], cur_q[33:32], cur_idx);
         DQ_OE <= !(cur_chop && ui_n[2]);
         DQS_OE <= !(cur_chop && ui_n[2]);
         DQS_OUT <= ~ui_n[0];
      end
      else
      begin
         DQ_OE <= 1'b0;
         DQS_OE <= state_q == ST_IDLE && f_pop;
         DQS_OUT <= 1'b0;
      end
   end

   always_ff @(posedge SYS_CLK or negedge RESET_N)
   begin
      if (!RESET_N)
      begin
         PATTERN_ACTIVE <= 1'b0;
      end
      else
      begin
         PATTERN_ACTIVE <= (CMD_VALID && CMD_OP == OP_MRS && CMD_MRSEL == 3'h3) ?
            CMD_ADDR[EN_BIT] : store_en;
      end
   end

   // ----------------------------------------
   // checks
   // ----------------------------------------
   default clocking @(posedge SYS_CLK); endclocking
   default disable iff (!RESET_N);

   a_page0_write: assert property (
      is_wr && store_en && page == 2'h0 && CMD_OP != OP_RST
      |=> pat_q[8*$past(CMD_BA) +: 8] == $past(CMD_ADDR[7:0]))
      else $error("page 0 write not stored");
   a_ro_pages: assert property (
      is_wr && page != 2'h0 |=> $stable(pat_q))
      else $error("read-only page written");
   a_off_noread: assert property (
      is_rd && !store_en |-> !rd_push)
      else $error("read queued outside pattern mode");
   a_chop_tristate: assert property (
      state_q == ST_BURST && cur_chop && ui_q[2] |-> !DQ_OE && !DQS_OE)
      else $error("chop tail driven");
   a_serial_lanes: assert property (
      DQ_OE && cur_q[37:36] == FMT_SERIAL |-> DQ_OUT == 8'h00 || DQ_OUT == 8'hFF)
      else $error("serial lanes differ");
   a_msb_first: assert property (
      state_q == ST_BURST && ui_q == 3'h0 && cur_q[37:36] == FMT_SERIAL && !cur_q[34]
      |-> DQ_OUT[0] == cur_q[8*cur_q[33:32] + 7])
      else $error("first interval not bit 7");
   a_latency: assert property (
      f_pop |=> (DQS_OE && !DQ_OE && !DQS_OUT) ##1 (DQ_OE && DQS_OUT))
      else $error("burst does not follow its preamble");
   a_due_time: assert property (
      rd_push && !f_valid |=> !f_pop)
      else $error("burst before read latency");
   a_burst_len: assert property (
      state_q == ST_PRE |=> (state_q == ST_BURST)[*8] ##1 state_q == ST_IDLE)
      else $error("burst not eight intervals");
   a_parallel_hold: assert property (
      state_q == ST_BURST && ui_q != 3'h0 && cur_q[37:36] == FMT_PARALLEL && DQ_OE
      |-> $stable(DQ_OUT))
      else $error("parallel byte changed");
   a_crc_sticky: assert property (
      el_crc_q |=> el_crc_q)
      else $error("crc status lost");
   a_mode_flag: assert property (
      CMD_VALID && CMD_OP == OP_MRS && CMD_MRSEL == 3'h3 |=> PATTERN_ACTIVE == $past(CMD_ADDR[2]))
      else $error("mode flag wrong");

   c_serial: cover property (state_q == ST_BURST && cur_q[37:36] == FMT_SERIAL);
   c_chop: cover property (state_q == ST_BURST && cur_chop && cur_q[34]);
   c_stagger: cover property (state_q == ST_BURST && cur_q[37:36] == FMT_STAGGER);
   c_full: cover property (!fifo_rdy);
endmodule : prs_pattern_access

/* tb/prs_ctrl_model.sv */
`timescale 1ns/1ns
module prs_ctrl_model
(
   // clock
   input wire logic clk,
   // command side
   output logic cmd_valid,
   output logic [2:0] cmd_op,
   output logic [2:0] cmd_mrsel,
   output logic [1:0] cmd_ba,
   output logic [prs_pkg::MR_BITS-1:0] cmd_addr,
   input wire logic cmd_ready,
   // read data side
   input wire logic [7:0] dq_out,
   input wire logic dq_oe,
   input wire logic dqs_out,
   input wire logic dqs_oe
);
   import prs_pkg::*;
   int cyc = 0;
   int rise_q[$];
   logic [8:0] rx_q[$];
   logic dqs_oe_q = 1'b0;
   logic pre_bad = 1'b0;
   initial
   begin
      cmd_valid = 1'b0;
      cmd_op = OP_DES;
      cmd_mrsel = 3'h0;
      cmd_ba = 2'h0;
      cmd_addr = 18'h0;
   end
   always @(posedge clk)
   begin
      cyc <= cyc + 1;
   end
   // --------------------------------
   // capture, half a cycle after launch so outputs have settled
   // --------------------------------
   always @(negedge clk)
   begin
      dqs_oe_q <= dqs_oe;
      if (dqs_oe && !dqs_oe_q)
      begin
         rise_q.push_back(cyc);
         pre_bad <= pre_bad | dq_oe | dqs_out;
      end
      if (dq_oe)
      begin
         rx_q.push_back({dqs_out, dq_out});
      end
   end
   // --------------------------------
   // command issue: only the allowed opcodes, burst fixed by mode zero
   // --------------------------------
   task automatic send(input logic [2:0] op, input logic [2:0] sel, input logic [1:0] ba,
      input logic [17:0] addr, output logic taken, output int at);
      @(negedge clk);
      cmd_valid = 1'b1;
      cmd_op = op;
      cmd_mrsel = sel;
      cmd_ba = ba;
      cmd_addr = addr;
      taken = cmd_ready;
      at = cyc;
      @(posedge clk);
   endtask : send
   // released bus shows a changed pattern, not the last command
   task automatic idle(input int n);
      @(negedge clk);
      cmd_valid = 1'b0;
      cmd_op = ~cmd_op;
      cmd_ba = ~cmd_ba;
      cmd_addr = ~cmd_addr;
      repeat (n) @(posedge clk);
   endtask : idle
endmodule : prs_ctrl_model

/* tb/testbench.sv */
`timescale 1ns/1ns
module testbench;
   import prs_pkg::*;
   logic sys_clk = 1'b0;
   logic reset_n = 1'b0;
   logic err_strobe = 1'b0;
   logic [17:0] err_addr = 18'h2A5C3;
   logic [5:0] err_ctrl = 6'h2D;
   logic [2:0] err_cid = 3'h5;
   logic err_crc = 1'b1;
   logic err_par = 1'b0;
   logic [1:0] temp = 2'h0;
   logic [3:0] act_cnt = 4'hA;
   logic cmd_valid, cmd_ready, dq_oe, dqs_out, dqs_oe, pat_active;
   logic [2:0] cmd_op, cmd_mrsel;
   logic [1:0] cmd_ba;
   logic [17:0] cmd_addr;
   logic [7:0] dq_out;
   int n_mismatch = 0;
   int checks = 0;
   int cycles = 0;
   int at, at0, nt;
   logic tk, on, chop, a12;
   logic [1:0] fmt;
   logic [7:0] pat [4];
   logic [7:0] p0 [4];
   logic [8:0] exp_q[$];
   always #25 sys_clk = ~sys_clk;
   prs_pattern_access prs_pattern_access_i (.SYS_CLK(sys_clk), .RESET_N(reset_n),
      .CMD_VALID(cmd_valid), .CMD_OP(cmd_op), .CMD_MRSEL(cmd_mrsel), .CMD_BA(cmd_ba),
      .CMD_ADDR(cmd_addr), .CMD_READY(cmd_ready), .ERR_STROBE(err_strobe),
      .ERR_ADDR(err_addr), .ERR_CTRL(err_ctrl), .ERR_CID(err_cid), .ERR_CRC(err_crc),
      .ERR_PAR(err_par), .TEMP_STATUS(temp), .ACT_COUNT(act_cnt), .DQ_OUT(dq_out),
      .DQ_OE(dq_oe), .DQS_OUT(dqs_out), .DQS_OE(dqs_oe), .PATTERN_ACTIVE(pat_active));
   prs_ctrl_model prs_ctrl_model_i (.clk(sys_clk), .cmd_valid(cmd_valid), .cmd_op(cmd_op),
      .cmd_mrsel(cmd_mrsel), .cmd_ba(cmd_ba), .cmd_addr(cmd_addr), .cmd_ready(cmd_ready),
      .dq_out(dq_out), .dq_oe(dq_oe), .dqs_out(dqs_out), .dqs_oe(dqs_oe));
   task automatic summarize;
      $display("checks %0d mismatches %0d", checks, n_mismatch);
      if (n_mismatch == 0 && checks > 0)
         $display("ALL CHECKS OK");
      else
         $display("CHECKS NOT OK");
      $finish;
   endtask : summarize
   always @(posedge sys_clk)
   begin
      cycles <= cycles + 1;
      if (cycles == 20000)
      begin
         n_mismatch++;
         summarize();
      end
   end
   task automatic cmp(input logic [8:0] got, input logic [8:0] exp, input string what);
      checks++;
      if (got !== exp)
      begin
         n_mismatch++;
         $display("wrong value at %0t: %s got %h expected %h", $time, what, got, exp);
      end
   endtask : cmp
   task automatic mrs(input logic [2:0] sel, input logic [17:0] val);
      prs_ctrl_model_i.send(OP_MRS, sel, 2'h0, val, tk, at);
      prs_ctrl_model_i.idle(4);
      if (sel == 3'h3)
         on = val[EN_BIT];
   endtask : mrs
   // expected stream is worked out when the read is taken
   task automatic rd(input logic [2:0] op, input logic [1:0] ba, input logic a2);
      logic [7:0] d;
      int bi;
      prs_ctrl_model_i.send(op, 3'h0, ba, {5'h0, a12, 9'h0, a2, 2'h0}, tk, at);
      nt += int'(tk);
      for (int k = 0; k < (chop ? 4 : 8); k++)
      begin
         bi = 7 - k - (a2 ? 4 : 0);
         for (int i = 0; i < 8; i++)
         begin
            case (fmt)
               FMT_PARALLEL: d[i] = pat[ba][7 - i];
               FMT_STAGGER: d[i] = pat[(ba + i) % 4][bi];
               default: d[i] = pat[ba][bi];
            endcase
         end
         if (on && tk)
            exp_q.push_back({~k[0], d});
      end
   endtask : rd
   task automatic drain(input string what);
      int n;
      n = 0;
      prs_ctrl_model_i.idle(1);
      while (prs_ctrl_model_i.rx_q.size() < exp_q.size() && n < 300)
      begin
         @(posedge sys_clk);
         n++;
      end
      repeat (12) @(posedge sys_clk);
      cmp(9'(prs_ctrl_model_i.rx_q.size()), 9'(exp_q.size()), what);
      while (exp_q.size() > 0 && prs_ctrl_model_i.rx_q.size() > 0)
         cmp(prs_ctrl_model_i.rx_q.pop_front(), exp_q.pop_front(), what);
      exp_q.delete();
      prs_ctrl_model_i.rx_q.delete();
      prs_ctrl_model_i.rise_q.delete();
      $display("test done: %s", what);
   endtask : drain
   initial
   begin
      on = 1'b0;
      chop = 1'b0;
      a12 = 1'b0;
      fmt = FMT_SERIAL;
      p0 = '{8'h55, 8'h33, 8'h0F, 8'h00};
      pat = p0;
      repeat (3) @(posedge sys_clk);
      @(negedge sys_clk);
      reset_n = 1'b1;
      @(negedge sys_clk);
      cmp({5'h0, cmd_ready, pat_active, dq_oe, dqs_oe}, 9'h008, "reset outputs");
      mrs(3'h5, 18'h01000);
      rd(OP_RD, 2'h0, 1'b0);
      drain("read with mode off");
      mrs(3'h3, 18'h00004);
      cmp({8'h0, pat_active}, 9'h001, "mode on");
      for (int l = 0; l < 4; l++)
      begin
         rd(OP_RD, 2'(l), 1'b0);
         if (l == 0)
            at0 = at;
      end
      drain("page 0 defaults back to back");
      cmp(9'(prs_ctrl_model_i.pre_bad), 9'h0, "preamble");
      prs_ctrl_model_i.send(OP_WR, 3'h0, 2'h1, 18'h000A5, tk, at);
      prs_ctrl_model_i.send(OP_WRA, 3'h0, 2'h2, 18'h0003C, tk, at);
      prs_ctrl_model_i.idle(2);
      p0[1] = 8'hA5;
      p0[2] = 8'h3C;
      pat = p0;
      rd(OP_RDA, 2'h1, 1'b0);
      rd(OP_RD, 2'h2, 1'b0);
      drain("page 0 write");
      mrs(3'h3, 18'h00804);
      fmt = FMT_PARALLEL;
      rd(OP_RD, 2'h0, 1'b0);
      drain("parallel");
      mrs(3'h3, 18'h01004);
      fmt = FMT_STAGGER;
      rd(OP_RD, 2'h1, 1'b0);
      drain("staggered");
      mrs(3'h0, 18'h00002);
      mrs(3'h3, 18'h00004);
      fmt = FMT_SERIAL;
      chop = 1'b1;
      rd(OP_RD, 2'h0, 1'b0);
      rd(OP_RD, 2'h1, 1'b1);
      drain("chop halves");
      mrs(3'h0, 18'h00001);
      chop = 1'b0;
      a12 = 1'b1;
      rd(OP_RD, 2'h3, 1'b0);
      drain("burst 8 with A12");
      mrs(3'h0, 18'h00000);
      a12 = 1'b0;
      nt = 0;
      for (int l = 0; l < 12; l++)
         rd(OP_RD, 2'h0, 1'b0);
      drain("queue full");
      cmp(9'(nt < 12), 9'h001, "refusal when full");
      // cl 10 from mode zero bit 2, al = cl-1 from mode one, cwl code 5
      mrs(3'h0, 18'h00004);
      mrs(3'h1, 18'h00008);
      mrs(3'h2, 18'h00028);
      mrs(3'h3, 18'h00006);
      pat[2] = 8'h0D;
      rd(OP_RD, 2'h2, 1'b0);
      at0 = at;
      drain("latency readout");
      for (int t = 0; t < 4; t++)
      begin
         @(negedge sys_clk);
         temp = 2'(t);
         pat[0] = {PPR_SUPPORT, SPPR_SUPPORT, 1'b0, temp, 3'h0};
         rd(OP_RD, 2'h0, 1'b0);
         drain("temperature field");
      end
      rd(OP_RD, 2'h2, 1'b0);
      at0 = at;
      prs_ctrl_model_i.idle(1);
      repeat (30) @(posedge sys_clk);
      // read latency of 19 plus the cycle from driving the command to its sampling edge
      cmp(9'(prs_ctrl_model_i.rise_q[0] - at0), 9'd20, "read latency");
      drain("latency stream");
      @(negedge sys_clk);
      err_strobe = 1'b1;
      @(negedge sys_clk);
      err_strobe = 1'b0;
      mrs(3'h3, 18'h00005);
      prs_ctrl_model_i.send(OP_WR, 3'h0, 2'h0, 18'h000FF, tk, at);
      pat = '{8'hC3, 8'hA5, 8'hB6, 8'h85};
      // reads from the log page keep the long column spacing
      for (int l = 0; l < 4; l++)
      begin
         rd(OP_RD, 2'(l), 1'b0);
         prs_ctrl_model_i.idle(1);
      end
      drain("error log");
      mrs(3'h3, 18'h00007);
      pat[3] = {4'h0, act_cnt};
      rd(OP_RD, 2'h3, 1'b0);
      drain("activate count");
      prs_ctrl_model_i.send(OP_RST, 3'h0, 2'h0, 18'h0, tk, at);
      prs_ctrl_model_i.idle(4);
      on = 1'b0;
      cmp({8'h0, pat_active}, 9'h000, "reinit mode");
      mrs(3'h3, 18'h00004);
      pat = '{8'h55, 8'h33, 8'h0F, 8'h00};
      rd(OP_RD, 2'h1, 1'b0);
      rd(OP_RD, 2'h2, 1'b0);
      drain("page 0 after reinit");
      mrs(3'h3, 18'h00000);
      summarize();
   end
endmodule : testbench
